/* src/annunciator_defs.vh */
`ifndef ANNUNCIATOR_DEFS_VH
`define ANNUNCIATOR_DEFS_VH

// ----------------------------------------
// flash timing, clock 40 MHz
// ----------------------------------------
`define CLK_HZ 40000000
// half periods in milliseconds
`define SLOW_HALF_MS 500
`define FAST_HALF_MS 250
`define QUICK_HALF_MS 100
// half periods in cycles, same times at 40 MHz, sized to the divider
`define SLOW_HALF_CYC 25'h1312D00
`define FAST_HALF_CYC 25'h0989680
`define QUICK_HALF_CYC 25'h03D0900
`define FLASH_CNT_W 25

// ----------------------------------------
// lamp modes, one-hot
// ----------------------------------------
`define LAMP_OFF 3'h1
`define LAMP_FLASH 3'h2
`define LAMP_STEADY 3'h4

`endif

/* src/flash_divider.v */
`timescale 1ns/1ps
// ----------------------------------------
// square wave, 50 percent duty
// ----------------------------------------
module flash_divider #(
  parameter [24:0] HALF_CYC = 25'h0000010
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // flash level
  output reg wave_q
);

  reg [24:0] cnt_q;

  // count one half period, then toggle
  always @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 25'h0000000;
      wave_q <= 1'b0;
    end else if (cnt_q >= HALF_CYC - 25'h0000001) begin
      cnt_q <= 25'h0000000;
      wave_q <= ~wave_q;
    end else begin
      cnt_q <= cnt_q + 25'h0000001;
    end
  end

endmodule

/* src/alarm_latch.v */
`timescale 1ns/1ps
`include "annunciator_defs.vh"
// ----------------------------------------
// one annunciation: flash, acknowledge, steady
// ----------------------------------------
module alarm_latch #(
  parameter AUTO_CLEAR = 1
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // condition and operator acknowledge
  input wire cond,
  input wire ack,
  // state
  output reg active_q,
  output reg acked_q,
  output wire [2:0] mode
);

  // latch alarm and its acknowledge; a new alarm beats a same-cycle ack
  always @(posedge ref_clk) begin
    if (reset) begin
      active_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (!active_q) begin
      active_q <= cond;
      acked_q <= 1'b0;
    end else if (AUTO_CLEAR != 0 && !cond) begin
      active_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (AUTO_CLEAR == 0 && !cond && acked_q) begin
      active_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (ack) begin
      acked_q <= 1'b1;
    end
  end

  // off, flashing until acked, then steady
  assign mode = !active_q ? `LAMP_OFF : (acked_q ? `LAMP_STEADY : `LAMP_FLASH);

endmodule

/* src/compressor_annunciator_lamps.v */
`timescale 1ns/1ps
`include "annunciator_defs.vh"
// Contract
// [R1] emergency stop forces run output off
// [R2] acknowledge still processed during emergency stop
// [R3] running lamp slow flash when ready
// [R4] running lamp faster flash while starting
// [R5] running lamp steady while running
// [R6] running lamp quick flash until motor off
// [R7] warning lamp flashes on warning condition
// [R8] operator acknowledge recorded for active warning
// [R9] warning clears itself when cause gone
// [R10] acknowledged warning lamp steady while present
// [R11] shutdown limit stops machine, flashes red
// [R12] acknowledged shutdown lamp steady while present
// [R13] red off only when cleared and acknowledged
// [R14] three clock-divided flash rates, half duty
// [R15] running lamp covers start, run, stop
module compressor_annunciator_lamps (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // compressor sequencer state
  input wire st_ready,
  input wire st_starting,
  input wire st_running,
  input wire st_stopping,
  input wire motor_off,
  input wire run_request,
  // condition detectors and panel
  input wire warn_cond,
  input wire shut_cond,
  input wire estop,
  input wire ack,
  // lamp drives, run output and status flags
  output reg run_lamp_q,
  output reg warn_lamp_q,
  output reg shut_lamp_q,
  output reg run_out_q,
  output reg warn_acked_q,
  output reg shut_active_q
);

  // ----------------------------------------
  // flash rates
  // ----------------------------------------
  wire slow_w;
  wire fast_w;
  wire quick_w;

  flash_divider #(.HALF_CYC(`SLOW_HALF_CYC)) u_slow ( // [R14]
    .ref_clk(ref_clk),
    .reset(reset),
    .wave_q(slow_w)
  );
  flash_divider #(.HALF_CYC(`FAST_HALF_CYC)) u_fast ( // [R14]
    .ref_clk(ref_clk),
    .reset(reset),
    .wave_q(fast_w)
  );
  flash_divider #(.HALF_CYC(`QUICK_HALF_CYC)) u_quick ( // [R14]
    .ref_clk(ref_clk),
    .reset(reset),
    .wave_q(quick_w)
  );

  // ----------------------------------------
  // annunciations
  // ----------------------------------------
  wire warn_act;
  wire warn_ack;
  wire [2:0] warn_mode;
  wire shut_act;
  wire shut_ack;
  wire [2:0] shut_mode;

  // ack input is not gated by estop
  alarm_latch #(.AUTO_CLEAR(1)) u_warn ( // [R7] [R8] [R9] [R10] [R2]
    .ref_clk(ref_clk),
    .reset(reset),
    .cond(warn_cond),
    .ack(ack),
    .active_q(warn_act),
    .acked_q(warn_ack),
    .mode(warn_mode)
  );
  alarm_latch #(.AUTO_CLEAR(0)) u_shut ( // [R11] [R12] [R13] [R2]
    .ref_clk(ref_clk),
    .reset(reset),
    .cond(shut_cond),
    .ack(ack),
    .active_q(shut_act),
    .acked_q(shut_ack),
    .mode(shut_mode)
  );

  // ----------------------------------------
  // running phase decode
  // ----------------------------------------
  localparam [4:0] RUN_IDLE = 5'h01;
  localparam [4:0] RUN_READY = 5'h02;
  localparam [4:0] RUN_START = 5'h04;
  localparam [4:0] RUN_ON = 5'h08;
  localparam [4:0] RUN_STOP = 5'h10;

  reg [4:0] run_state_q;
  reg [4:0] run_state_d;

  // phase priority: stopping, running, starting, ready
  always @* begin
    run_state_d = RUN_IDLE;
    if (st_stopping && !motor_off) begin
      run_state_d = RUN_STOP; // [R6] [R15]
    end else if (st_running) begin
      run_state_d = RUN_ON; // [R5] [R15]
    end else if (st_starting) begin
      run_state_d = RUN_START; // [R4] [R15]
    end else if (st_ready) begin
      run_state_d = RUN_READY; // [R3]
    end
  end

  // phase register, idle out of reset
  always @(posedge ref_clk) begin
    if (reset) begin
      run_state_q <= RUN_IDLE;
    end else begin
      run_state_q <= run_state_d;
    end
  end

  // ----------------------------------------
  // lamp drive
  // ----------------------------------------
  reg run_lamp_d;
  reg warn_lamp_d;
  reg shut_lamp_d;

  // running lamp by decoded phase
  always @* begin
    case (run_state_q)
      RUN_READY: begin
        run_lamp_d = slow_w; // [R3]
      end
      RUN_START: begin
        run_lamp_d = fast_w; // [R4]
      end
      RUN_ON: begin
        run_lamp_d = 1'b1; // [R5]
      end
      RUN_STOP: begin
        run_lamp_d = quick_w; // [R6]
      end
      default: begin
        run_lamp_d = 1'b0;
      end
    endcase
  end

  // warning lamp by latch mode
  always @* begin
    case (warn_mode)
      `LAMP_FLASH: begin
        warn_lamp_d = fast_w; // [R7]
      end
      `LAMP_STEADY: begin
        warn_lamp_d = 1'b1; // [R10]
      end
      default: begin
        warn_lamp_d = 1'b0; // [R9]
      end
    endcase
  end

  // shutdown lamp by latch mode
  always @* begin
    case (shut_mode)
      `LAMP_FLASH: begin
        shut_lamp_d = fast_w; // [R11]
      end
      `LAMP_STEADY: begin
        shut_lamp_d = 1'b1; // [R12]
      end
      default: begin
        shut_lamp_d = 1'b0; // [R13]
      end
    endcase
  end

  // ----------------------------------------
  // run permit and status
  // ----------------------------------------
  wire run_block;
  wire run_out_d;
  wire warn_acked_d;
  wire shut_active_d;

  // estop is never masked; a raw or latched shutdown blocks too
  assign run_block = estop || shut_act || shut_cond; // [R1] [R11]
  assign run_out_d = run_request && !run_block;
  // acknowledged only while the warning stands
  assign warn_acked_d = warn_act && warn_ack; // [R8]
  // latched shutdown still waiting for the operator
  assign shut_active_d = shut_act && !shut_ack;

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // running lamp
  always @(posedge ref_clk) begin
    if (reset) begin
      run_lamp_q <= 1'b0;
    end else begin
      run_lamp_q <= run_lamp_d;
    end
  end

  // warning lamp
  always @(posedge ref_clk) begin
    if (reset) begin
      warn_lamp_q <= 1'b0;
    end else begin
      warn_lamp_q <= warn_lamp_d;
    end
  end

  // shutdown lamp
  always @(posedge ref_clk) begin
    if (reset) begin
      shut_lamp_q <= 1'b0;
    end else begin
      shut_lamp_q <= shut_lamp_d;
    end
  end

  // compressor run output, one edge after a stop cause
  always @(posedge ref_clk) begin
    if (reset) begin
      run_out_q <= 1'b0;
    end else begin
      run_out_q <= run_out_d; // [R1] [R11]
    end
  end

  // warning acknowledged flag
  always @(posedge ref_clk) begin
    if (reset) begin
      warn_acked_q <= 1'b0;
    end else begin
      warn_acked_q <= warn_acked_d; // [R8]
    end
  end

  // shutdown awaiting acknowledge
  always @(posedge ref_clk) begin
    if (reset) begin
      shut_active_q <= 1'b0;
    end else begin
      shut_active_q <= shut_active_d; // [R12]
    end
  end

endmodule

/* verif/seq_model.sv */
`timescale 1ns/1ps
// sequencer: phase code to levels
module seq_model (
  input wire [2:0] phase,
  output wire st_ready, st_starting, st_running, st_stopping, motor_off
);
  // one phase at a time, motor off when idle
  assign st_ready = phase == 3'h1;
  assign st_starting = phase == 3'h2;
  assign st_running = phase == 3'h3;
  assign st_stopping = phase == 3'h4;
  assign motor_off = phase == 3'h0;
endmodule

/* verif/ann_chk_sva.sv */
`timescale 1ns/1ps
module ann_chk (
  input wire ref_clk, reset, st_ready, st_starting, st_running, st_stopping,
  input wire motor_off, run_request, warn_cond, shut_cond, estop, ack,
  input wire run_lamp_q, warn_lamp_q, shut_lamp_q, run_out_q, warn_acked_q, shut_active_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_stop; estop |=> !run_out_q; endproperty
  a_stop: assert property (p_stop) else $error("run in stop");
  property p_shrun; shut_cond |=> !run_out_q; endproperty
  a_shrun: assert property (p_shrun) else $error("run in shutdown");
  property p_run; (st_running && !st_stopping)[*4] |-> run_lamp_q; endproperty
  a_run: assert property (p_run) else $error("run lamp");
  property p_wst; warn_acked_q && $past(warn_acked_q) |-> warn_lamp_q; endproperty
  a_wst: assert property (p_wst) else $error("warn steady");
  property p_wclr; (!warn_cond)[*3] |-> !warn_lamp_q && !warn_acked_q; endproperty
  a_wclr: assert property (p_wclr) else $error("warn clear");
  property p_hold; (!ack)[*3] ##0 $rose(shut_active_q) ##1 (!ack)[*4] |-> shut_active_q;
  endproperty
  a_hold: assert property (p_hold) else $error("shut hold");
  property p_lat; $rose(shut_cond) |-> ##[1:3] shut_active_q; endproperty
  a_lat: assert property (p_lat) else $error("shut latch");
  property p_ack; warn_cond[*3] ##0 ack ##1 warn_cond[*2] |-> warn_acked_q; endproperty
  a_ack: assert property (p_ack) else $error("warn ack");
endmodule
bind compressor_annunciator_lamps ann_chk ann_chk_inst (.*);

/* verif/compressor_annunciator_lamps_bench.sv */
`timescale 1ns/1ps
module compressor_annunciator_lamps_bench;
  reg ref_clk = 0, reset = 1, run_request = 1, warn_cond = 0, shut_cond = 0, estop = 0, ack = 0;
  reg [2:0] phase = 3'h0;
  wire st_ready, st_starting, st_running, st_stopping, motor_off;
  wire run_lamp_q, warn_lamp_q, shut_lamp_q, run_out_q, warn_acked_q, shut_active_q;
  wire [5:0] obs = {run_lamp_q, warn_lamp_q, shut_lamp_q, run_out_q, warn_acked_q, shut_active_q};
  integer failures = 0, num_checks = 0, seed = 32'h21a63ec8;
  reg [11:0] notes[$];
  reg [11:0] n;
  event look;
  seq_model seq_model_inst (.phase(phase), .st_ready(st_ready), .st_starting(st_starting),
    .st_running(st_running), .st_stopping(st_stopping), .motor_off(motor_off));
  compressor_annunciator_lamps compressor_annunciator_lamps_inst (.ref_clk(ref_clk),
    .reset(reset), .st_ready(st_ready), .st_starting(st_starting), .st_running(st_running),
    .st_stopping(st_stopping), .motor_off(motor_off), .run_request(run_request),
    .warn_cond(warn_cond), .shut_cond(shut_cond), .estop(estop), .ack(ack),
    .run_lamp_q(run_lamp_q), .warn_lamp_q(warn_lamp_q), .shut_lamp_q(shut_lamp_q),
    .run_out_q(run_out_q), .warn_acked_q(warn_acked_q), .shut_active_q(shut_active_q));
  // clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // settle, note {mask, value}
  task ex(input [5:0] m, input [5:0] v);
    begin
      repeat (5 + ($random(seed) & 3)) @(negedge ref_clk);
      notes.push_back({m, v});
      -> look;
      @(negedge ref_clk);
      $display("test done");
    end
  endtask
  // one operator acknowledge
  task pa;
    begin
      ack = 1;
      @(negedge ref_clk);
      ack = 0;
    end
  endtask
  // compare oldest note
  always @(look) begin
    n = notes.pop_front();
    num_checks = num_checks + 1;
    if ((obs & n[11:6]) !== n[5:0]) begin
      failures = failures + 1;
      $display("mismatch outputs expected %h seen %h", n[5:0], obs);
    end
  end
  task close_out;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #20000;
    failures = failures + 1;
    close_out;
  end
  // tests
  initial begin
    repeat (4) @(negedge ref_clk);
    reset = 0;
    phase = 3'h3;
    ex(6'h24, 6'h24);
    estop = 1;
    warn_cond = 1;
    ex(6'h06, 6'h00);
    pa;
    ex(6'h12, 6'h12);
    warn_cond = 0;
    estop = 0;
    ex(6'h12, 6'h00);
    shut_cond = 1;
    ex(6'h05, 6'h01);
    shut_cond = 0;
    ex(6'h01, 6'h01);
    shut_cond = 1;
    pa;
    ex(6'h09, 6'h08);
    shut_cond = 0;
    ex(6'h0D, 6'h04);
    phase = 3'h0;
    ex(6'h20, 6'h00);
    // random phases; flash levels stay low long after reset
    repeat (4) begin
      phase = {$random(seed)} % 5;
      ex(6'h20, {phase == 3'h3, 5'h00});
    end
    close_out;
  end
endmodule
